// File: verilog/branch_condition_select.sv
`timescale 1ns/1ps

package branch_pkg;
   // Instruction word and status word are numbered 0 (msb) to 31 (lsb)
   localparam int WORD_W = 32;
   localparam int ADDR_W = 18;
   localparam int REG_ADDR_W = 8;

   // Opcodes (instruction bits 0-5) and selector codes (bits 6-8)
   localparam logic [5:0] OP_TRUE_GROUP = 6'h3b;
   localparam logic [5:0] OP_FALSE = 6'h3c;
   localparam logic [5:0] OP_LINK_GROUP = 6'h3e;
   localparam logic [2:0] SEL_NONE = 3'h0;
   localparam logic [2:0] SEL_RETURN = 3'h2;

   // Field positions
   localparam int OPC_LO = 0;
   localparam int OPC_HI = 5;
   localparam int SEL_LO = 6;
   localparam int SEL_HI = 8;
   localparam int IDX_LO = 9;
   localparam int IDX_HI = 10;
   localparam int IND_BIT = 11;
   localparam int ADDR_LO = 13;
   localparam int ADDR_HI = 30;
   localparam int CC_LO = 1;
   localparam int CC_HI = 4;
   localparam int RET_LO = 5;
   localparam int RET_HI = 6;
   localparam int STAT_BUSY = 0;
   localparam int STAT_TAKEN = 1;
   localparam int STAT_ILLEGAL = 2;

   // Register offsets
   localparam logic [7:0] REG_PSW = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_INDEX1 = 8'h08;
   localparam logic [7:0] REG_INDEX2 = 8'h0c;
   localparam logic [7:0] REG_INDEX3 = 8'h10;

   // Reset values
   localparam logic [0:31] PSW_RESET = 32'h00000000;
   localparam logic [0:31] INDEX_RESET = 32'h00000000;

   typedef struct packed {
      logic [5:0] opcode;
      logic [2:0] select;
      logic [1:0] index;
      logic indirect;
      logic [ADDR_W-1:0] address;
   } branch_word_t;

   typedef enum {ST_IDLE, ST_FETCH} state_t;

   typedef enum {KIND_NONE, KIND_UNCOND, KIND_TRUE, KIND_FALSE, KIND_RETURN} branch_kind_t;

   function automatic branch_word_t decode_word(input logic [0:31] w);
      branch_word_t d;
      d.opcode = w[OPC_LO:OPC_HI];
      d.select = w[SEL_LO:SEL_HI];
      d.index = w[IDX_LO:IDX_HI];
      d.indirect = w[IND_BIT];
      d.address = w[ADDR_LO:ADDR_HI];
      return d;
   endfunction
endpackage

module branch_condition_select import branch_pkg::*; (
   input wire logic [1:4] cc,
   input wire logic [2:0] select,
   input wire logic onTrue,
   output logic taken
);
   logic trueHit;
   logic falseHit;

   // Branch on true
   assign trueHit = (select == 3'h1) ? cc[1] :
                    (select == 3'h2) ? cc[2] :
                    (select == 3'h3) ? cc[3] :
                    (select == 3'h4) ? cc[4] :
                    (select == 3'h5) ? (cc[2] | cc[4]) :
                    (select == 3'h6) ? (cc[3] | cc[4]) :
                    (select == 3'h7) ? (cc[1] | cc[2] | cc[4]) : 1'b0;

   // Branch on false
   assign falseHit = (select == 3'h1) ? ~cc[1] :
                     (select == 3'h2) ? ~cc[2] :
                     (select == 3'h3) ? ~cc[3] :
                     (select == 3'h4) ? ~cc[4] :
                     (select == 3'h5) ? ~(cc[2] | cc[4]) :
                     (select == 3'h6) ? ~(cc[3] | cc[4]) :
                     (select == 3'h7) ? ~(|cc) : 1'b0;

   assign taken = onTrue ? trueHit : falseHit;
endmodule // branch_condition_select

// File: verilog/branch_condition_unit.sv
// Summary of operation
// - Unconditional branch copies address bits 13-30 into status word bits 13-30.
// - Direct unconditional branch leaves status word bits 1-12 untouched.
// - Indirect unconditional branch loads status bits 1-4 from the final chain word.
// - Unconditional branch never changes bit 0 or the extended-mode bit.
// - Bits 5 and 6 change only for an indirect special return branch.
// - Direct unconditional branch keeps all four condition bits.
// - Indirect branch sets condition bits 1-4 from the final chain word.
// - Branch on false loads address bits 13-30 only when the selected bits are all clear.
// - Condition not met leaves the program counter field unchanged.
// - Indirect conditional branch loads status bits 1-4 only when taken.
// - Conditional branch keeps bit 0 and bits 5-12 unchanged.
// - False selectors 1-4 test one clear bit; selector 5 needs bits 2,4 clear.
// - False selector 6 needs bits 3,4 clear; selector 7 needs all clear.
// - True selectors 1-4 one bit set; 5: 2|4; 6: 3|4; 7: 1|2|4.
// - Direct conditional branch leaves condition bits unchanged.
// - Decode opcode 0-5, selector 6-8, index 9-10, indirect 11, address 13-30.
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps

module branch_condition_unit import branch_pkg::*; (
   input wire logic clk,
   input wire logic srst,
   input wire logic [REG_ADDR_W-1:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData,
   input wire logic instrValid,
   input wire logic [0:31] instrWord,
   output logic memReq,
   output logic [ADDR_W-1:0] memAddr,
   input wire logic memAck,
   input wire logic [0:31] memData,
   output logic [0:31] psw,
   output logic busy,
   output logic branchDone,
   output logic branchTaken,
   output logic illegalOp
);
   logic [0:31] indexReg [1:3];
   state_t state;
   logic returnPending;
   logic [0:31] next_psw;
   logic [31:0] next_regRdData;

   branch_word_t instr;
   branch_word_t fetchWord;
   branch_kind_t kind;
   logic [ADDR_W-1:0] instrEa;
   logic [ADDR_W-1:0] fetchEa;
   logic condTaken;
   logic taken;
   logic idle;
   logic accept;
   logic startDirect;
   logic startChain;
   logic chainNext;
   logic chainEnd;
   logic finishNow;
   logic regWrite;
   logic pswWrite;
   logic [31:0] statusWord;

   // Index added to the address field; index 0 means no indexing
   function automatic logic [ADDR_W-1:0] effective_address(input branch_word_t w,
         input logic [0:31] x1, input logic [0:31] x2, input logic [0:31] x3);
      logic [ADDR_W-1:0] offs;
      offs = (w.index == 2'h1) ? x1[ADDR_LO:ADDR_HI] :
             (w.index == 2'h2) ? x2[ADDR_LO:ADDR_HI] :
             (w.index == 2'h3) ? x3[ADDR_LO:ADDR_HI] : '0;
      return ADDR_W'(w.address + offs);
   endfunction

   // Instruction decode
   assign instr = decode_word(instrWord);
   assign fetchWord = decode_word(memData);
   assign kind = (instr.opcode == OP_TRUE_GROUP && instr.select == SEL_NONE) ? KIND_UNCOND :
                 (instr.opcode == OP_TRUE_GROUP) ? KIND_TRUE :
                 (instr.opcode == OP_FALSE) ? KIND_FALSE :
                 (instr.opcode == OP_LINK_GROUP && instr.select == SEL_RETURN) ? KIND_RETURN :
                 KIND_NONE;
   assign instrEa = effective_address(instr, indexReg[1], indexReg[2], indexReg[3]);
   assign fetchEa = effective_address(fetchWord, indexReg[1], indexReg[2], indexReg[3]);

   // Condition judged on the present condition bits
   branch_condition_select u_branch_condition_select (
      .cc(psw[CC_LO:CC_HI]),
      .select(instr.select),
      .onTrue(kind == KIND_TRUE),
      .taken(condTaken)
   );

   assign taken = (kind == KIND_UNCOND || kind == KIND_RETURN) ? 1'b1 :
                  (kind == KIND_TRUE || kind == KIND_FALSE) ? condTaken : 1'b0;

   // Sequencing terms
   assign idle = (state == ST_IDLE);
   assign accept = idle && instrValid;
   assign startDirect = accept && taken && !instr.indirect;
   assign startChain = accept && taken && instr.indirect;
   assign chainNext = (state == ST_FETCH) && memAck && fetchWord.indirect;
   assign chainEnd = (state == ST_FETCH) && memAck && !fetchWord.indirect;
   assign finishNow = (accept && !startChain) || chainEnd;

   // Register writes only while idle
   assign regWrite = idle && regWr && !instrValid;
   assign pswWrite = regWrite && (regAddr == REG_PSW);

   // Status word update
   always_comb begin
      next_psw = psw;
      if (pswWrite) begin
         next_psw = regWrData;
      end
      if (startDirect) begin
         next_psw[ADDR_LO:ADDR_HI] = instrEa;
         // Bits 0-12 kept, condition bits kept
      end
      if (chainEnd) begin
         next_psw[ADDR_LO:ADDR_HI] = fetchEa;
         next_psw[CC_LO:CC_HI] = memData[CC_LO:CC_HI];
         if (returnPending) begin
            next_psw[RET_LO:RET_HI] = memData[RET_LO:RET_HI];
         end
         // Bit 0 and bits 7-12 never taken from the chain word
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         psw <= PSW_RESET;
      end else begin
         psw <= next_psw;
      end
   end

   // Index registers
   always_ff @(posedge clk) begin
      if (srst) begin
         indexReg[1] <= INDEX_RESET;
         indexReg[2] <= INDEX_RESET;
         indexReg[3] <= INDEX_RESET;
      end else if (regWrite) begin
         if (regAddr == REG_INDEX1) begin
            indexReg[1] <= regWrData;
         end
         if (regAddr == REG_INDEX2) begin
            indexReg[2] <= regWrData;
         end
         if (regAddr == REG_INDEX3) begin
            indexReg[3] <= regWrData;
         end
      end
   end

   // Indirect chain walker
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= ST_IDLE;
         returnPending <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (startChain) begin
                  state <= ST_FETCH;
                  returnPending <= (kind == KIND_RETURN);
               end
            end
            ST_FETCH: begin
               if (chainEnd) begin
                  state <= ST_IDLE;
                  returnPending <= 1'b0;
               end
            end
         endcase
      end
   end

   // Memory request for indirect words
   always_ff @(posedge clk) begin
      if (srst) begin
         memReq <= 1'b0;
         memAddr <= '0;
      end else begin
         if (startChain) begin
            memReq <= 1'b1;
            memAddr <= instrEa;
         end else if (chainNext) begin
            memAddr <= fetchEa;
         end else if (chainEnd) begin
            memReq <= 1'b0;
         end
      end
   end

   // Completion flags
   always_ff @(posedge clk) begin
      if (srst) begin
         busy <= 1'b0;
         branchDone <= 1'b0;
         branchTaken <= 1'b0;
         illegalOp <= 1'b0;
      end else begin
         busy <= startChain || ((state == ST_FETCH) && !chainEnd);
         branchDone <= finishNow;
         if (finishNow) begin
            branchTaken <= chainEnd || startDirect;
         end
         if (accept) begin
            illegalOp <= (kind == KIND_NONE);
         end
      end
   end

   // Register read
   assign statusWord = {29'h0000000, illegalOp, branchTaken, busy};
   assign next_regRdData = !regRd ? 32'h00000000 :
                           (regAddr == REG_PSW) ? psw :
                           (regAddr == REG_STATUS) ? statusWord :
                           (regAddr == REG_INDEX1) ? indexReg[1] :
                           (regAddr == REG_INDEX2) ? indexReg[2] :
                           (regAddr == REG_INDEX3) ? indexReg[3] : 32'h00000000;

   always_ff @(posedge clk) begin
      if (srst) begin
         regRdData <= 32'h00000000;
      end else begin
         regRdData <= next_regRdData;
      end
   end
endmodule // branch_condition_unit

// File: verification/branch_condition_unit_monitor.sv
`timescale 1ns/1ps
module branch_condition_unit_monitor import branch_pkg::*; (
   input wire logic clk,
   input wire logic srst,
   input wire logic instrValid,
   input wire logic [0:31] instrWord,
   input wire logic memReq,
   input wire logic [ADDR_W-1:0] memAddr,
   input wire logic memAck,
   input wire logic [0:31] memData,
   input wire logic [0:31] psw,
   input wire logic busy,
   input wire logic branchDone,
   input wire logic branchTaken
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   wire start = instrValid && !busy;
   wire fin = memReq && memAck && memData[9:10] == 2'h0;
   a_fetch_start: assert property (start && instrWord[0:11] == {OP_TRUE_GROUP, 6'h01}
      |=> memReq && memAddr == $past(instrWord[13:30])) else $error("bad first fetch");
   a_direct_done: assert property (start && !instrWord[11] |=> branchDone)
      else $error("direct branch not done");
   a_chain_next: assert property (fin && memData[11]
      |=> memReq && memAddr == $past(memData[13:30])) else $error("bad chain step");
   a_final_load: assert property (fin && !memData[11] |=> branchDone && !busy
      && psw[1:4] == $past(memData[1:4]) && psw[13:30] == $past(memData[13:30]))
      else $error("bad final load");
   a_edge_kept: assert property (branchDone |-> psw[0] == $past(psw[0])
      && psw[31] == $past(psw[31])) else $error("bit 0 or 31 changed");
   a_mid_kept: assert property (branchDone |-> $stable(psw[7:12]))
      else $error("bits 7-12 changed");
   a_cc_direct: assert property (branchDone && !$past(busy) |-> $stable(psw[1:6]))
      else $error("direct branch changed bits 1-6");
   a_not_taken: assert property (branchDone && !branchTaken |-> $stable(psw))
      else $error("status word changed without branch");
   c_taken: cover property (branchDone && branchTaken);
   c_chain: cover property (fin && memData[11]);
   c_skip: cover property (branchDone && !branchTaken);
endmodule // branch_condition_unit_monitor

bind branch_condition_unit branch_condition_unit_monitor u_branch_condition_unit_monitor (
   .clk(clk), .srst(srst), .instrValid(instrValid), .instrWord(instrWord), .memReq(memReq),
   .memAddr(memAddr), .memAck(memAck), .memData(memData), .psw(psw), .busy(busy),
   .branchDone(branchDone), .branchTaken(branchTaken));

// File: verification/branch_condition_unit_tb.sv
`timescale 1ns/1ps
module branch_condition_unit_tb import branch_pkg::*;;
   logic clk = 0, srst = 1, regWr = 0, regRd = 0, instrValid = 0, memAck = 0;
   logic [7:0] regAddr = 0;
   logic [31:0] regWrData = 0, regRdData;
   logic [0:31] instrWord = 0, memData = 0, psw;
   logic memReq, busy, branchDone, branchTaken, illegalOp;
   logic [ADDR_W-1:0] memAddr;
   int failCount = 0, comparisons = 0, cyc = 0;
   branch_condition_unit u_branch_condition_unit (.clk(clk), .srst(srst), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .instrValid(instrValid), .instrWord(instrWord), .memReq(memReq), .memAddr(memAddr),
      .memAck(memAck), .memData(memData), .psw(psw), .busy(busy), .branchDone(branchDone),
      .branchTaken(branchTaken), .illegalOp(illegalOp));
   initial forever #12.5 clk = ~clk;
   task automatic tally_and_finish();
      if (failCount == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         failCount++;
         tally_and_finish();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         failCount++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   function automatic logic [0:31] mk(logic [5:0] op, logic [2:0] s, logic i, logic [17:0] a);
      return {op, s, 2'h0, i, 1'h0, a, 1'h0};
   endfunction
   // Expected branch decision from the pre-branch condition bits
   function automatic logic cond(logic [1:4] c, logic [2:0] s, logic t);
      logic [1:7] m, f;
      m = {c[1], c[2], c[3], c[4], c[2] | c[4], c[3] | c[4], c[1] | c[2] | c[4]};
      f = {~c[1], ~c[2], ~c[3], ~c[4], ~(c[2] | c[4]), ~(c[3] | c[4]), c == 4'h0};
      if (s == 3'h0) return t;
      return t ? m[s] : f[s];
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regWr <= 1'h1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      regRd <= 1'h1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'h0;
      #1 chk("regRdData", e, regRdData);
   endtask
   task automatic issue(input logic [0:31] i);
      @(posedge clk);
      instrValid <= 1'h1;
      instrWord <= i;
      @(posedge clk);
      instrValid <= 1'h0;
      #1;
   endtask
   task automatic serve(input logic [17:0] a, input logic [0:31] w);
      chk("memReq", 32'h1, memReq);
      chk("memAddr", a, memAddr);
      chk("busy", 32'h1, busy);
      @(posedge clk);
      memAck <= 1'h1;
      memData <= w;
      @(posedge clk);
      memAck <= 1'h0;
      memData <= ~w;
      #1;
   endtask
   task automatic t_regs();
      rd(REG_PSW, 32'h0);
      rd(REG_STATUS, 32'h0);
      wr(REG_PSW, 32'h50001000);
      rd(REG_PSW, 32'h50001000);
      rd(8'hfc, 32'h0);
   endtask
   task automatic t_cond();
      logic [31:0] old, exp;
      logic tk;
      for (int op = 0; op < 2; op++) begin
         for (int c = 0; c < 16; c++) begin
            for (int s = 0; s < 8; s++) begin
               old = {1'h1, c[3:0], 27'h2aaaaaa};
               tk = cond(c[3:0], s[2:0], op == 0);
               exp = tk ? {old[31:19], 18'h15a5a, old[0]} : old;
               wr(REG_PSW, old);
               issue(mk(op == 0 ? OP_TRUE_GROUP : OP_FALSE, s[2:0], 1'h0, 18'h15a5a));
               chk("branchDone", 32'h1, branchDone);
               chk("branchTaken", tk, branchTaken);
               chk("psw", exp, psw);
            end
         end
      end
   endtask
   task automatic t_ind(input logic [5:0] op, input logic [2:0] s);
      logic [0:31] w1, w2, exp;
      w1 = mk(6'h3e, 3'h7, 1'h1, 18'h00a20);
      w2 = mk(6'h15, 3'h3, 1'h0, 18'h2b3c4);
      exp = {1'h1, w2[1:4], (op == OP_LINK_GROUP) ? w2[5:6] : 2'h0, 6'h0, w2[13:30], 1'h1};
      wr(REG_PSW, 32'h80001001);
      issue(mk(op, s, 1'h1, 18'h01414));
      serve(18'h01414, w1);
      serve(18'h00a20, w2);
      chk("branchDone", 32'h1, branchDone);
      chk("psw", exp, psw);
   endtask
   task automatic t_skip();
      wr(REG_PSW, 32'h80001000);
      issue(mk(OP_TRUE_GROUP, 3'h1, 1'h1, 18'h01414));
      chk("memReq", 32'h0, memReq);
      chk("psw", 32'h80001000, psw);
      chk("branchTaken", 32'h0, branchTaken);
   endtask
   task automatic t_misc();
      wr(REG_INDEX2, 32'h00000200);
      rd(REG_INDEX2, 32'h00000200);
      wr(REG_PSW, 32'h80001000);
      issue(mk(OP_LINK_GROUP, SEL_RETURN, 1'h0, 18'h01414) | 32'h00400000);
      chk("psw", 32'h80002a28, psw);
      issue(mk(6'h00, SEL_NONE, 1'h0, 18'h01414));
      chk("illegalOp", 32'h1, illegalOp);
      chk("branchTaken", 32'h0, branchTaken);
      rd(REG_STATUS, 32'h4);
      issue(mk(OP_TRUE_GROUP, SEL_NONE, 1'h1, 18'h01414));
      wr(REG_PSW, 32'h0);
      rd(REG_STATUS, 32'h1);
      issue(mk(OP_TRUE_GROUP, SEL_NONE, 1'h0, 18'h00004));
      chk("branchDone", 32'h0, branchDone);
      serve(18'h01414, mk(6'h15, 3'h3, 1'h0, 18'h2b3c4));
      chk("psw", 32'hd0056788, psw);
      chk("busy", 32'h0, busy);
      chk("branchTaken", 32'h1, branchTaken);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      srst <= 1'h0;
      t_regs();
      t_cond();
      t_ind(OP_TRUE_GROUP, SEL_NONE);
      t_ind(OP_LINK_GROUP, SEL_RETURN);
      t_ind(OP_FALSE, 3'h7);
      t_skip();
      t_misc();
      tally_and_finish();
   end
endmodule // branch_condition_unit_tb
